/* shared/nbd_pkg.sv */
// shared constants and types for the nibble core instruction decoder
package nbd_pkg;
	localparam int WORD_W = 12;
	localparam int NIB_W = 4;
	localparam int STEP_W = 8;

	// opcode prefixes on bits 11..8
	localparam logic [3:0] OP_JP = 4'h0;
	localparam logic [3:0] OP_RETD = 4'h1;
	localparam logic [3:0] OP_JP_C = 4'h2;
	localparam logic [3:0] OP_JP_NC = 4'h3;
	localparam logic [3:0] OP_CALL = 4'h4;
	localparam logic [3:0] OP_CALZ = 4'h5;
	localparam logic [3:0] OP_JP_Z = 4'h6;
	localparam logic [3:0] OP_JP_NZ = 4'h7;
	localparam logic [3:0] OP_ADD_I = 4'hC;
	// opcode prefixes on bits 11..6, 11..5
	localparam logic [5:0] OP_LD_I = 6'h38;
	localparam logic [6:0] OP_PSET = 7'h72;
	// opcode prefixes on bits 11..4
	localparam logic [7:0] OP_ADD_RQ = 8'hA8;
	localparam logic [7:0] OP_SUB_RQ = 8'hAA;
	localparam logic [7:0] OP_SET_F = 8'hF4;
	localparam logic [7:0] OP_RST_F = 8'hF5;
	localparam logic [7:0] OP_LD_A_MN = 8'hFA;
	// whole-word opcodes
	localparam logic [11:0] OP_JPBA = 12'hFE8;
	localparam logic [11:0] OP_HALT = 12'hFF8;
	localparam logic [11:0] OP_NOP5 = 12'hFFB;
	localparam logic [11:0] OP_NOP7 = 12'hFFF;
	localparam logic [11:0] OP_RET = 12'hFDF;
	localparam logic [11:0] OP_RETS = 12'hFDE;
	// word that the family uses for sleep; refused on this device
	localparam logic [11:0] SLEEP_OPCODE = 12'hFF9;

	// values after reset, zero-page call page and decimal adjust constants
	localparam logic PC_BANK_RST = 1'h0;
	localparam logic [3:0] PC_PAGE_RST = 4'h1;
	localparam logic [7:0] PC_STEP_RST = 8'h00;
	localparam logic [3:0] FLAGS_RST = 4'h0;
	localparam logic [3:0] CALZ_PAGE = 4'h0;
	localparam logic [3:0] BCD_MAX = 4'h9;
	localparam logic [3:0] BCD_ADJ = 4'h6;

	typedef enum logic [1:0] {
		RSEL_A = 2'h0,
		RSEL_B = 2'h1,
		RSEL_MX = 2'h2,
		RSEL_MY = 2'h3
	} nbd_rsel_e;

	typedef enum logic [9:0] {
		CLS_NOP = 10'h001,
		CLS_JP = 10'h002,
		CLS_JPC = 10'h004,
		CLS_JPBA = 10'h008,
		CLS_PSET = 10'h010,
		CLS_CALL = 10'h020,
		CLS_ALU = 10'h040,
		CLS_LDI = 10'h080,
		CLS_FLAG = 10'h100,
		CLS_HALT = 10'h200
	} nbd_cls_e;

	typedef enum logic [1:0] {
		ST_RUN = 2'h1,
		ST_HALT = 2'h2
	} nbd_st_e;

	typedef struct packed {
		logic pc_bank_field;
		logic [3:0] pc_page_field;
		logic [3:0] pc_step_high_nibble;
		logic [3:0] pc_step_low_nibble;
	} nbd_pc_s;

	typedef struct packed {
		logic irq_en;
		logic decimal;
		logic zero;
		logic carry;
	} nbd_flags_s;

	typedef struct packed {
		logic valid;
		nbd_cls_e cls;
		nbd_rsel_e r_sel;
		nbd_rsel_e q_sel;
		logic [3:0] imm4;
		logic [4:0] imm5;
		logic [7:0] imm8;
		logic sub;
		logic bcd_ok;
		logic cond_z;
		logic cond_neg;
		logic zero_page;
		logic direct_mn;
		logic stack_op;
		logic refused;
	} nbd_dec_s;
endpackage

/* hdl/nbd_nibble_alu.sv */
// nibble adder and subtractor with optional decimal adjust
`timescale 1ns/100ps
`default_nettype none
module nbd_nibble_alu
	import nbd_pkg::*;
(
	input wire logic [NIB_W-1:0] a_i,
	input wire logic [NIB_W-1:0] b_i,
	input wire logic sub_i,
	input wire logic bcd_i,
	output logic [NIB_W-1:0] res_o,
	output logic carry_o
);
	logic [4:0] raw;

	always_comb
	begin
		raw = sub_i ? ({1'h0, a_i} - {1'h0, b_i}) : ({1'h0, a_i} + {1'h0, b_i});
		res_o = raw[3:0];
		carry_o = raw[4];
		if (bcd_i && !sub_i && (raw[4] || raw[3:0] > BCD_MAX))
		begin
			res_o = raw[3:0] + BCD_ADJ;
			carry_o = 1'h1;
		end
		else if (bcd_i && sub_i && raw[4])
		begin
			res_o = raw[3:0] - BCD_ADJ;
			carry_o = 1'h1;
		end
	end
endmodule
`default_nettype wire

/* hdl/nbd_decoder.sv */
// instruction decoder, program counter and flags of the nibble core
// How it works
// - all 108 instruction types are single 12-bit words, decoded per fetch.
// - the sleep word is refused and executed as no operation.
// - flags interrupt enable, decimal, zero, carry, each settable individually.
// - with decimal flag set, marked add and subtract give BCD results.
// - five-bit page-set operand: top bit to bank, low four to page pointer.
// - eight-bit jump and call operand loads the step within a page.
// - four-bit immediate for data loads and direct low memory addressing.
// - eight-bit step split in high and low nibbles, always loaded together.
`timescale 1ns/100ps
`default_nettype none
module nbd_decoder
	import nbd_pkg::*;
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic en_i,
	input wire logic instr_valid_i,
	input wire logic [WORD_W-1:0] instr_i,
	input wire logic wake_i,
	input wire logic [NIB_W-1:0] opr_r_i,
	input wire logic [NIB_W-1:0] opr_q_i,
	input wire logic [NIB_W-1:0] reg_a_i,
	input wire logic [NIB_W-1:0] reg_b_i,
	output logic rdy_o,
	output nbd_pkg::nbd_dec_s dec_o,
	output nbd_pkg::nbd_pc_s pc_o,
	output nbd_pkg::nbd_flags_s flags_o,
	output logic pend_bank_o,
	output logic [NIB_W-1:0] pend_page_o,
	output logic wr_en_o,
	output nbd_pkg::nbd_rsel_e wr_sel_o,
	output logic [NIB_W-1:0] wr_data_o,
	output logic halt_o,
	output logic refused_o
);
	import nbd_pkg::*;

	function automatic nbd_dec_s nbd_decode(input logic [WORD_W-1:0] w);
		nbd_dec_s d;
		d = '0;
		d.valid = 1'h1;
		d.cls = CLS_NOP;
		d.r_sel = nbd_rsel_e'(w[3:2]);
		d.q_sel = nbd_rsel_e'(w[1:0]);
		d.imm4 = w[3:0];
		d.imm5 = w[4:0];
		d.imm8 = w[7:0];
		d.cond_z = w[10];
		d.cond_neg = w[8];
		if (w == SLEEP_OPCODE)
			d.refused = 1'h1;
		else if (w[11:8] == OP_JP)
			d.cls = CLS_JP;
		else if (w[11:8] == OP_JP_C || w[11:8] == OP_JP_NC ||
			w[11:8] == OP_JP_Z || w[11:8] == OP_JP_NZ)
			d.cls = CLS_JPC;
		else if (w[11:8] == OP_CALL || w[11:8] == OP_CALZ)
		begin
			d.cls = CLS_CALL;
			d.zero_page = w[8];
			d.stack_op = 1'h1;
		end
		else if (w[11:8] == OP_RETD || w == OP_RET || w == OP_RETS)
			d.stack_op = 1'h1;
		else if (w[11:5] == OP_PSET)
			d.cls = CLS_PSET;
		else if (w == OP_JPBA)
			d.cls = CLS_JPBA;
		else if (w == OP_HALT)
			d.cls = CLS_HALT;
		else if (w[11:8] == OP_ADD_I)
		begin
			d.cls = CLS_ALU;
			d.r_sel = nbd_rsel_e'(w[5:4]);
			d.bcd_ok = 1'h1;
		end
		else if (w[11:6] == OP_LD_I)
		begin
			d.cls = CLS_LDI;
			d.r_sel = nbd_rsel_e'(w[5:4]);
		end
		else if (w[11:4] == OP_ADD_RQ || w[11:4] == OP_SUB_RQ)
		begin
			d.cls = CLS_ALU;
			d.sub = w[5];
			d.bcd_ok = 1'h1;
		end
		else if (w[11:4] == OP_SET_F || w[11:4] == OP_RST_F)
		begin
			d.cls = CLS_FLAG;
			d.sub = w[4];
		end
		else if (w[11:4] == OP_LD_A_MN)
			d.direct_mn = 1'h1;
		return d;
	endfunction

	nbd_dec_s dec_r, dec_nxt;
	logic rdy_r, rdy_nxt;
	logic take;

	// fetch stage: one whole word per accepted fetch
	always_comb
	begin
		take = instr_valid_i && rdy_r;
		dec_nxt = '0;
		if (take)
			dec_nxt = nbd_decode(instr_i);
	end

	nbd_st_e st_r, st_nxt;
	nbd_pc_s pc_r, pc_nxt;
	nbd_flags_s flg_r, flg_nxt;
	logic pending_bank_pointer_r, pending_bank_pointer_nxt;
	logic [3:0] pending_page_pointer_r, pending_page_pointer_nxt;
	logic wr_en_r, wr_en_nxt;
	nbd_rsel_e wr_sel_r, wr_sel_nxt;
	logic [3:0] wr_data_r, wr_data_nxt;
	logic refused_r, refused_nxt;
	logic exec;
	logic jump_ok;
	logic [3:0] alu_b;
	logic [3:0] alu_res;
	logic alu_carry;

	assign alu_b = (dec_r.q_sel == nbd_rsel_e'(dec_r.imm4[1:0]) &&
		dec_r.imm4 == dec_r.imm8[3:0] && dec_r.imm8[7:4] == OP_ADD_RQ[3:0] ||
		dec_r.imm8[7:4] == OP_SUB_RQ[3:0]) ? opr_q_i : dec_r.imm4;

	nbd_nibble_alu u_alu (
		.a_i(opr_r_i),
		.b_i(alu_b),
		.sub_i(dec_r.sub),
		.bcd_i(dec_r.bcd_ok && flg_r.decimal),
		.res_o(alu_res),
		.carry_o(alu_carry)
	);

	// execute stage
	always_comb
	begin
		exec = dec_r.valid && (st_r == ST_RUN);
		st_nxt = st_r;
		pc_nxt = pc_r;
		flg_nxt = flg_r;
		pending_bank_pointer_nxt = pending_bank_pointer_r;
		pending_page_pointer_nxt = pending_page_pointer_r;
		wr_en_nxt = 1'h0;
		wr_sel_nxt = wr_sel_r;
		wr_data_nxt = wr_data_r;
		refused_nxt = 1'h0;
		jump_ok = (dec_r.cond_z ? flg_r.zero : flg_r.carry) ^ dec_r.cond_neg;
		case (st_r)
			ST_RUN:
			begin
				if (exec)
				begin
					refused_nxt = dec_r.refused;
					{pc_nxt.pc_step_high_nibble, pc_nxt.pc_step_low_nibble} =
						{pc_r.pc_step_high_nibble, pc_r.pc_step_low_nibble}
						+ 8'h01;
					case (dec_r.cls)
						CLS_JP, CLS_JPC:
						begin
							if (dec_r.cls == CLS_JP || jump_ok)
							begin
								pc_nxt.pc_bank_field = pending_bank_pointer_r;
								pc_nxt.pc_page_field = pending_page_pointer_r;
								{pc_nxt.pc_step_high_nibble,
									pc_nxt.pc_step_low_nibble} = dec_r.imm8;
							end
						end
						CLS_JPBA:
						begin
							pc_nxt.pc_bank_field = pending_bank_pointer_r;
							pc_nxt.pc_page_field = pending_page_pointer_r;
							pc_nxt.pc_step_high_nibble = reg_b_i;
							pc_nxt.pc_step_low_nibble = reg_a_i;
						end
						CLS_CALL:
						begin
							pc_nxt.pc_page_field = dec_r.zero_page ? CALZ_PAGE
								: pending_page_pointer_r;
							{pc_nxt.pc_step_high_nibble,
								pc_nxt.pc_step_low_nibble} = dec_r.imm8;
						end
						CLS_PSET:
						begin
							pending_bank_pointer_nxt = dec_r.imm5[4];
							pending_page_pointer_nxt = dec_r.imm5[3:0];
						end
						CLS_ALU:
						begin
							wr_en_nxt = 1'h1;
							wr_sel_nxt = dec_r.r_sel;
							wr_data_nxt = alu_res;
							flg_nxt.zero = (alu_res == 4'h0);
							flg_nxt.carry = alu_carry;
						end
						CLS_LDI:
						begin
							wr_en_nxt = 1'h1;
							wr_sel_nxt = dec_r.r_sel;
							wr_data_nxt = dec_r.imm4;
						end
						CLS_FLAG:
						begin
							if (dec_r.sub)
								flg_nxt = nbd_flags_s'(flg_r & ~dec_r.imm4);
							else
								flg_nxt = nbd_flags_s'(flg_r | dec_r.imm4);
						end
						CLS_HALT:
							st_nxt = ST_HALT;
						default:
							pc_nxt = pc_nxt;
					endcase
				end
			end
			ST_HALT:
			begin
				if (wake_i)
					st_nxt = ST_RUN;
			end
			default:
				st_nxt = ST_RUN;
		endcase
		rdy_nxt = (st_nxt == ST_RUN) && !take;
	end

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			dec_r <= '0;
			rdy_r <= 1'h0;
			st_r <= ST_RUN;
			pc_r <= {PC_BANK_RST, PC_PAGE_RST, PC_STEP_RST};
			flg_r <= nbd_flags_s'(FLAGS_RST);
			pending_bank_pointer_r <= PC_BANK_RST;
			pending_page_pointer_r <= PC_PAGE_RST;
			wr_en_r <= 1'h0;
			wr_sel_r <= RSEL_A;
			wr_data_r <= 4'h0;
			refused_r <= 1'h0;
		end
		else if (en_i)
		begin
			dec_r <= dec_nxt;
			rdy_r <= rdy_nxt;
			st_r <= st_nxt;
			pc_r <= pc_nxt;
			flg_r <= flg_nxt;
			pending_bank_pointer_r <= pending_bank_pointer_nxt;
			pending_page_pointer_r <= pending_page_pointer_nxt;
			wr_en_r <= wr_en_nxt;
			wr_sel_r <= wr_sel_nxt;
			wr_data_r <= wr_data_nxt;
			refused_r <= refused_nxt;
		end
	end

	assign rdy_o = rdy_r;
	assign dec_o = dec_r;
	assign pc_o = pc_r;
	assign flags_o = flg_r;
	assign pend_bank_o = pending_bank_pointer_r;
	assign pend_page_o = pending_page_pointer_r;
	assign wr_en_o = wr_en_r;
	assign wr_sel_o = wr_sel_r;
	assign wr_data_o = wr_data_r;
	// one-hot bit of the halt state
	assign halt_o = st_r[1];
	assign refused_o = refused_r;
endmodule
`default_nettype wire

/* testbench/nbd_chk.sv */
// port checker for the nibble decoder
`timescale 1ns/100ps
`default_nettype none
module nbd_chk
	import nbd_pkg::*;
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic en_i,
	input wire logic instr_valid_i,
	input wire logic [WORD_W-1:0] instr_i,
	input wire logic rdy_o,
	input wire nbd_pkg::nbd_dec_s dec_o,
	input wire nbd_pkg::nbd_pc_s pc_o,
	input wire nbd_pkg::nbd_flags_s flags_o,
	input wire logic pend_bank_o,
	input wire logic [NIB_W-1:0] pend_page_o,
	input wire logic wr_en_o,
	input wire nbd_pkg::nbd_rsel_e wr_sel_o,
	input wire logic [NIB_W-1:0] wr_data_o,
	input wire logic halt_o,
	input wire logic refused_o
);
	logic take;
	logic [7:0] step;
	logic [11:0] w1_r, w2_r;
	assign take = en_i && instr_valid_i && rdy_o;
	assign step = {pc_o.pc_step_high_nibble, pc_o.pc_step_low_nibble};
	// word taken two cycles back, lined up with its results
	always_ff @(posedge clk_i)
	begin
		w1_r <= instr_i;
		w2_r <= w1_r;
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);
	sequence took_s(c);
		take && c ##2 1'b1;
	endsequence
	take_dec_a: assert property (take |=> dec_o.valid ##1 !dec_o.valid)
		else $error("decode pulse wrong");
	sleep_ref_a: assert property (
		took_s(instr_i == SLEEP_OPCODE) |-> refused_o && !halt_o)
		else $error("sleep word not refused");
	pset_ptr_a: assert property (
		took_s(instr_i[11:5] == OP_PSET)
		|-> {pend_bank_o, pend_page_o} == w2_r[4:0])
		else $error("pending pointers wrong");
	jp_load_a: assert property (
		took_s(instr_i[11:8] == OP_JP)
		|-> pc_o == {pend_bank_o, pend_page_o, w2_r[7:0]})
		else $error("jump target wrong");
	calz_load_a: assert property (
		took_s(instr_i[11:8] == OP_CALZ)
		|-> pc_o.pc_page_field == CALZ_PAGE && step == w2_r[7:0])
		else $error("zero page call wrong");
	step_inc_a: assert property (
		took_s(instr_i == OP_NOP5) |-> step == $past(step, 2) + 8'h01)
		else $error("step not advanced");
	flag_set_a: assert property (
		took_s(instr_i[11:4] == OP_SET_F)
		|-> flags_o == ($past(flags_o, 2) | w2_r[3:0]))
		else $error("flag set wrong");
	flag_clr_a: assert property (
		took_s(instr_i[11:4] == OP_RST_F)
		|-> flags_o == ($past(flags_o, 2) & ~w2_r[3:0]))
		else $error("flag clear wrong");
	ld_write_a: assert property (
		took_s(instr_i[11:6] == OP_LD_I) |-> wr_en_o
		&& wr_sel_o == w2_r[5:4] && wr_data_o == w2_r[3:0])
		else $error("load write wrong");
endmodule
bind nbd_decoder nbd_chk u_chk (.clk_i, .nrst_i, .en_i, .instr_valid_i,
	.instr_i, .rdy_o, .dec_o, .pc_o, .flags_o, .pend_bank_o, .pend_page_o,
	.wr_en_o, .wr_sel_o, .wr_data_o, .halt_o, .refused_o);
`default_nettype wire

/* testbench/nbd_mem_model.sv */
// registers and data memory beside the decoder
`timescale 1ns/100ps
`default_nettype none
module nbd_mem_model
	import nbd_pkg::*;
#(
	parameter logic [NIB_W-1:0] INIT_A = 4'h9,
	parameter logic [NIB_W-1:0] INIT_B = 4'h3
)
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire nbd_pkg::nbd_dec_s dec_i,
	input wire logic wr_en_i,
	input wire nbd_pkg::nbd_rsel_e wr_sel_i,
	input wire logic [NIB_W-1:0] wr_data_i,
	output logic [NIB_W-1:0] opr_r_o,
	output logic [NIB_W-1:0] opr_q_o,
	output logic [NIB_W-1:0] reg_a_o,
	output logic [NIB_W-1:0] reg_b_o
);
	logic [NIB_W-1:0] regs_r [4];
	logic [NIB_W-1:0] regs_nxt [4];
	always_comb
	begin
		regs_nxt = regs_r;
		if (wr_en_i)
			regs_nxt[wr_sel_i] = wr_data_i;
	end
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			regs_r <= '{INIT_A, INIT_B, 4'h7, 4'hC};
		else
			regs_r <= regs_nxt;
	end
	// operands scrambled outside the decode cycle
	always_comb
	begin
		opr_r_o = regs_r[dec_i.r_sel] ^ {NIB_W{!dec_i.valid}};
		opr_q_o = regs_r[dec_i.q_sel] ^ {NIB_W{!dec_i.valid}};
	end
	assign reg_a_o = regs_r[0];
	assign reg_b_o = regs_r[1];
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
// self-checking bench for the nibble decoder
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import nbd_pkg::*;
	localparam logic [3:0] INIT_A = 4'h9;
	localparam logic [3:0] INIT_B = 4'h3;
	logic clk_i, nrst_i, en_i, instr_valid_i, wake_i;
	logic [WORD_W-1:0] instr_i;
	logic [NIB_W-1:0] opr_r_i, opr_q_i, reg_a_i, reg_b_i;
	logic [NIB_W-1:0] pend_page_o, wr_data_o;
	logic rdy_o, pend_bank_o, wr_en_o, halt_o, refused_o;
	nbd_dec_s dec_o;
	nbd_pc_s pc_o;
	nbd_flags_s flags_o;
	nbd_rsel_e wr_sel_o;
	nbd_cls_e cls;
	nbd_dec_s dec;
	int failures, tests_run;
	nbd_decoder dut (.clk_i, .nrst_i, .en_i, .instr_valid_i, .instr_i,
		.wake_i, .opr_r_i, .opr_q_i, .reg_a_i, .reg_b_i, .rdy_o, .dec_o,
		.pc_o, .flags_o, .pend_bank_o, .pend_page_o, .wr_en_o, .wr_sel_o,
		.wr_data_o, .halt_o, .refused_o);
	nbd_mem_model #(.INIT_A(INIT_A), .INIT_B(INIT_B)) mem (.clk_i,
		.nrst_i, .dec_i(dec_o), .wr_en_i(wr_en_o), .wr_sel_i(wr_sel_o),
		.wr_data_i(wr_data_o), .opr_r_o(opr_r_i), .opr_q_o(opr_q_i),
		.reg_a_o(reg_a_i), .reg_b_o(reg_b_i));
	initial
	begin
		clk_i = 1'h0;
		forever #12.5 clk_i = ~clk_i;
	end
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e)
		begin
			$display("mismatch %s expected %h seen %h", nm, e, g);
			failures++;
		end
	endtask
	// one word: wait for ready, hold valid for one cycle, return in the result cycle
	task issue(input logic [11:0] w);
		int n;
		n = 0;
		while (rdy_o !== 1'h1 && n < 50)
		begin
			@(negedge clk_i);
			n++;
		end
		@(posedge clk_i);
		instr_valid_i <= 1'h1;
		instr_i <= w;
		@(posedge clk_i);
		instr_valid_i <= 1'h0;
		@(negedge clk_i);
		cls = dec_o.cls;
		dec = dec_o;
		@(negedge clk_i);
	endtask
	task alu(input logic [11:0] w, input logic [3:0] d, input logic c);
		issue(w);
		chk("alu data", d, wr_data_o);
		chk("carry", c, flags_o.carry);
		chk("zero", d == 4'h0, flags_o.zero);
	endtask
	task t_reset;
		@(negedge clk_i);
		chk("pc", {PC_BANK_RST, PC_PAGE_RST, PC_STEP_RST}, pc_o);
		chk("flags", FLAGS_RST, flags_o);
		$display("reset test done");
	endtask
	task t_branch;
		issue({OP_PSET, 5'h1A});
		chk("pend", 16'h1A, {pend_bank_o, pend_page_o});
		issue({OP_JP, 8'hFF});
		chk("cls", CLS_JP, cls);
		chk("pc jp", 16'h1AFF, pc_o);
		issue(OP_NOP5);
		chk("pc wrap", 16'h1A00, pc_o);
		issue({OP_PSET, 5'h03});
		issue(OP_JPBA);
		chk("pc jpba", {5'h03, INIT_B, INIT_A}, pc_o);
		issue(SLEEP_OPCODE);
		chk("refused", 16'h1, refused_o);
		chk("pc sleep", {5'h03, INIT_B, INIT_A + 4'h1}, pc_o);
		$display("branch test done");
	endtask
	task t_regs;
		for (int r = 0; r < 4; r++)
		begin
			issue({OP_LD_I, 2'(r), 4'(r + 5)});
			chk("cls", CLS_LDI, cls);
			chk("wr en", 16'h1, wr_en_o);
			chk("wr sel", 16'(r), wr_sel_o);
			chk("wr data", 16'(r + 5), wr_data_o);
		end
		$display("register test done");
	endtask
	task t_flags;
		logic [3:0] m;
		m = 4'h0;
		issue({OP_RST_F, 4'hF});
		chk("flags clr", 16'h0, flags_o);
		for (int k = 0; k < 8; k++)
		begin
			m = (k < 4) ? m | 4'(1 << k) : m & ~4'(1 << (k - 4));
			issue({(k < 4) ? OP_SET_F : OP_RST_F, 4'(1 << (k % 4))});
			chk("flags", m, flags_o);
		end
		$display("flag test done");
	endtask
	task t_bcd;
		issue({OP_LD_I, 2'h0, 4'h9});
		issue({OP_SET_F, 4'h4});
		alu({OP_ADD_I, 4'h0, 4'h1}, 4'h0, 1'h1);
		alu({OP_SUB_RQ, 4'h1}, 4'h4, 1'h1);
		alu({OP_ADD_RQ, 4'h2}, 4'h1, 1'h1);
		issue({OP_RST_F, 4'h4});
		alu({OP_ADD_I, 4'h0, 4'h9}, 4'hA, 1'h0);
		$display("decimal test done");
	endtask
	task t_jump;
		issue({OP_PSET, 5'h15});
		issue({OP_RST_F, 4'hF});
		issue({OP_JP, 8'h10});
		chk("pc jp", 16'h1510, pc_o);
		issue({OP_JP_C, 8'h40});
		chk("cls", CLS_JPC, cls);
		chk("pc jp c", 16'h1511, pc_o);
		issue({OP_JP_NC, 8'h40});
		chk("pc jp nc", 16'h1540, pc_o);
		issue({OP_JP_Z, 8'h60});
		chk("pc jp z", 16'h1541, pc_o);
		issue({OP_JP_NZ, 8'h80});
		chk("pc jp nz", 16'h1580, pc_o);
		issue({OP_SET_F, 4'h3});
		issue({OP_JP_C, 8'h20});
		chk("pc jp c2", 16'h1520, pc_o);
		issue({OP_JP_NZ, 8'h30});
		chk("pc jp nz2", 16'h1521, pc_o);
		issue({OP_PSET, 5'h07});
		issue({OP_CALL, 8'h33});
		chk("call stack", 16'h1, dec.stack_op);
		chk("pc call", 16'h1733, pc_o);
		issue({OP_CALZ, 8'h44});
		chk("calz page", 16'h1, dec.zero_page);
		chk("pc calz", 16'h1044, pc_o);
		issue(OP_RET);
		chk("ret stack", 16'h1, dec.stack_op);
		chk("pc ret", 16'h1045, pc_o);
		issue({OP_LD_A_MN, 4'h5});
		chk("direct", 16'h1, dec.direct_mn);
		chk("direct n", 16'h5, dec.imm4);
		chk("pend kept", 16'h07, {pend_bank_o, pend_page_o});
		$display("jump test done");
	endtask
	// halt, a word offered while halted is ignored, then wake
	task t_halt;
		issue(OP_HALT);
		chk("halt", 16'h1, halt_o);
		chk("rdy halt", 16'h0, rdy_o);
		chk("pc halt", 16'h1047, pc_o);
		@(posedge clk_i);
		instr_valid_i <= 1'h1;
		instr_i <= {OP_PSET, 5'h1F};
		repeat (2) @(posedge clk_i);
		instr_valid_i <= 1'h0;
		wake_i <= 1'h1;
		@(posedge clk_i);
		wake_i <= 1'h0;
		@(negedge clk_i);
		chk("halt woke", 16'h0, halt_o);
		chk("rdy woke", 16'h1, rdy_o);
		chk("pend refused", 16'h07, {pend_bank_o, pend_page_o});
		issue(OP_NOP5);
		chk("pc run", 16'h1048, pc_o);
		$display("halt test done");
	endtask
	// reset pulse in mid-run, then the first jump after it
	task t_rst2;
		@(posedge clk_i);
		nrst_i <= 1'h0;
		@(negedge clk_i);
		chk("pc rst", {PC_BANK_RST, PC_PAGE_RST, PC_STEP_RST}, pc_o);
		chk("pend rst", {PC_BANK_RST, PC_PAGE_RST},
			{pend_bank_o, pend_page_o});
		chk("rdy rst", 16'h0, rdy_o);
		chk("halt rst", 16'h0, halt_o);
		@(posedge clk_i);
		nrst_i <= 1'h1;
		issue({OP_JP, 8'h22});
		chk("pc jp rst", {PC_BANK_RST, PC_PAGE_RST, 8'h22}, pc_o);
		$display("second reset test done");
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		{nrst_i, instr_valid_i, wake_i} = 3'h0;
		en_i = 1'h1;
		instr_i = 12'h000;
		failures = 0;
		tests_run = 0;
		repeat (10) @(posedge clk_i);
		t_reset;
		@(posedge clk_i);
		nrst_i <= 1'h1;
		t_branch;
		t_regs;
		t_flags;
		t_bcd;
		t_jump;
		t_halt;
		t_rst2;
		test_done;
	end
	initial
	begin
		repeat (3000) @(posedge clk_i);
		failures++;
		test_done;
	end
endmodule
`default_nettype wire
